// >>> logic/dpsmc_pkg.sv
`default_nettype none

package dpsmc_pkg;

    // Datapath geometry.
    localparam int DW = 8;
    localparam int CFG_WORDS = 8;
    localparam int CFG_WORD_W = 16;
    localparam int ROUTE_CH = 6;
    localparam int NUM_IN = 9;
    localparam int SEL_W = 3;
    localparam int APB_AW = 12;
    localparam int APB_DW = 32;

    // Index of each routed input inside the selector array.
    localparam int IN_ADDR0 = 0;
    localparam int IN_ADDR1 = 1;
    localparam int IN_ADDR2 = 2;
    localparam int IN_QUEUE0 = 3;
    localparam int IN_QUEUE1 = 4;
    localparam int IN_OPER0 = 5;
    localparam int IN_OPER1 = 6;
    localparam int IN_SHIFT = 7;
    localparam int IN_CARRY = 8;

    // Register byte offsets.
    localparam logic [APB_AW-1:0] OFS_SHIFT_CFG = 12'h000;
    localparam logic [APB_AW-1:0] OFS_TOP_BIT = 12'h004;
    localparam logic [APB_AW-1:0] OFS_MASK = 12'h008;
    localparam logic [APB_AW-1:0] OFS_CARRY_CFG = 12'h00C;
    localparam logic [APB_AW-1:0] OFS_INPUT_SEL = 12'h010;
    localparam logic [APB_AW-1:0] OFS_ACCUM = 12'h014;
    localparam logic [APB_AW-1:0] OFS_OPERAND = 12'h018;
    localparam logic [APB_AW-1:0] OFS_QUEUE = 12'h01C;
    localparam logic [APB_AW-1:0] OFS_STATUS = 12'h020;
    localparam logic [APB_AW-1:0] OFS_DYN_BASE = 12'h040;

    // Reset values.
    localparam logic [DW-1:0] RST_MASK = 8'hFF;
    localparam logic [2:0] RST_TOP_IDX = 3'h7;

    typedef enum logic [2:0] {
        FN_PASS = 3'b000,
        FN_INC = 3'b001,
        FN_DEC = 3'b010,
        FN_ADD = 3'b011,
        FN_SUB = 3'b100,
        FN_XOR = 3'b101,
        FN_AND = 3'b110,
        FN_OR = 3'b111
    } dpsmc_func_t;

    typedef enum logic [1:0] {
        SH_PASS = 2'b00,
        SH_LEFT = 2'b01,
        SH_RIGHT = 2'b10,
        SH_SWAP = 2'b11
    } dpsmc_shift_t;

    // Shared by shift-in and carry-in source selection.
    typedef enum logic [1:0] {
        SRC_DEFAULT = 2'b00,
        SRC_REGISTERED = 2'b01,
        SRC_ROUTED = 2'b10,
        SRC_CHAINED = 2'b11
    } dpsmc_src_t;

    typedef enum logic [1:0] {
        QS_NONE = 2'b00,
        QS_ACC0 = 2'b01,
        QS_ACC1 = 2'b10,
        QS_ALU = 2'b11
    } dpsmc_qsrc_t;

    typedef enum logic [1:0] {
        OB_OPER0 = 2'b00,
        OB_OPER1 = 2'b01,
        OB_ACC0 = 2'b10,
        OB_ACC1 = 2'b11
    } dpsmc_opb_t;

    typedef enum logic [1:0] {
        WR_NONE = 2'b00,
        WR_ALU = 2'b01,
        WR_SHIFT = 2'b10,
        WR_QUEUE = 2'b11
    } dpsmc_wr_t;

    // One word of dynamic_config_word memory, bit 0 is func[0].
    typedef struct packed {
        logic spare;
        dpsmc_wr_t acc1_wr;
        dpsmc_wr_t acc0_wr;
        logic crc_feedback_enable;
        logic carry_sel_b;
        logic shift_sel_b;
        dpsmc_shift_t shift;
        dpsmc_opb_t srcb;
        logic srca_acc1;
        dpsmc_func_t func;
    } dpsmc_dyn_word_t;

    typedef struct packed {
        logic msb_shift_in;
        logic default_shift_bit;
        dpsmc_src_t shift_in_source_b;
        dpsmc_src_t shift_in_source_a;
        logic out_sel_left;
    } dpsmc_shift_cfg_t;

    typedef struct packed {
        logic chain_top_bit;
        logic chain_feedback;
        logic top_enable;
        logic [2:0] top_idx;
    } dpsmc_top_cfg_t;

    typedef struct packed {
        dpsmc_qsrc_t queue1_source_select;
        dpsmc_qsrc_t queue0_source_select;
        dpsmc_src_t carry_source_b;
        dpsmc_src_t carry_source_a;
    } dpsmc_carry_cfg_t;

    typedef struct packed {
        logic shift_from_left;
        logic shift_from_right;
        logic carry;
        logic crc_feedback;
        logic top_bit;
    } dpsmc_chain_in_t;

    typedef struct packed {
        logic shift_to_left;
        logic shift_to_right;
        logic carry;
        logic crc_feedback;
        logic top_bit;
    } dpsmc_chain_out_t;

    typedef struct packed {
        logic [CFG_WORDS-1:0][CFG_WORD_W-1:0] dyn;
        dpsmc_shift_cfg_t shift_cfg;
        dpsmc_top_cfg_t top_cfg;
        logic [DW-1:0] alu_result_mask;
        dpsmc_carry_cfg_t carry_cfg;
        logic [NUM_IN-1:0][SEL_W-1:0] in_sel;
        logic [DW-1:0] accumulator_zero;
        logic [DW-1:0] accumulator_one;
        logic [DW-1:0] operand_reg_zero;
        logic [DW-1:0] operand_reg_one;
        logic [DW-1:0] queue0;
        logic [DW-1:0] queue1;
        logic sol;
        logic sor;
        logic carry;
        logic [3:0] load_prev;
        logic [3:0] load_pend;
        logic shift_out;
        dpsmc_chain_out_t chain_out;
        logic [APB_DW-1:0] prdata;
        logic pready;
        logic pslverr;
    } dpsmc_state_t;

endpackage

`default_nettype wire

// >>> logic/dpsmc_shifter.sv
`default_nettype none

module dpsmc_shifter #(
    parameter int DW = dpsmc_pkg::DW,
    parameter int IW = $clog2(DW)
) (
    // Value and operation.
    input wire logic [DW-1:0] value,
    input wire dpsmc_pkg::dpsmc_shift_t mode,
    input wire logic [IW-1:0] top_idx,
    // Bits entering at bit 0 and at the top position.
    input wire logic si_left,
    input wire logic si_right,
    // Result and the bits leaving either side.
    output logic [DW-1:0] result,
    output logic shift_out_left,
    output logic shift_out_right
);

    logic [DW-1:0] shl;
    logic [DW-1:0] shr;

    for (genvar i = 0; i < DW; i++) begin : g_bit
        if (i == 0) begin : g_lo
            assign shl[i] = si_left;
        end else begin : g_hi
            assign shl[i] = value[i-1];
        end
        if (i == DW - 1) begin : g_top
            assign shr[i] = si_right;
        end else begin : g_mid
            assign shr[i] = (i == int'(top_idx)) ? si_right : value[i+1];
        end
    end

    assign shift_out_left = value[top_idx];
    assign shift_out_right = value[0];

    always_comb begin
        unique case (mode)
            dpsmc_pkg::SH_PASS: result = value;
            dpsmc_pkg::SH_LEFT: result = shl;
            dpsmc_pkg::SH_RIGHT: result = shr;
            dpsmc_pkg::SH_SWAP: result = {value[DW/2-1:0], value[DW-1:DW/2]};
        endcase
    end

endmodule

`default_nettype wire

// >>> logic/dpsmc_top.sv
// What this block does
// - Shifter follows the masked ALU result: pass, left, right or nibble swap.
// - One static bit picks left or right shift-out for the shared output.
// - Without a shift, right out is result LSb, left out is the result bit at the top position.
// - Dynamic word picks shift-in source A or B each cycle.
// - Shift-in data matters only for left and right shifts and for CRC feedback.
// - Source 00 gives the default bit, or top bit on right shift.
// - Source 01 gives the matching shift-out registered last cycle.
// - Source 10 gives the routed shift-in input.
// - Source 11 takes shift-in from the neighbouring slices.
// - Left out comes from top position; right shift enters there.
// - Both shift-out bits are registered every cycle.
// - Bits above the top still shift; their outs are dropped.
// - ALU result is ANDed with a programmable 8-bit mask.
// - Nine inputs, each picked from six routing channels.
// - Three routed address bits pick one of eight 16-bit words.
// - Queue load rising edge loads queue from its source on the second clock edge after it.
// - Operand load rising edge loads operand from its queue on the second clock edge after it.
// - Routed carry matters only when routed carry is selected.
// - Address, shift and carry inputs are levels; loads are edges.
// - Top bit XOR shift-in forms CRC feedback, chained to all slices.
// - Feedback gates operand B when enabled, else forced high.
`default_nettype none

module dpsmc_top #(
    parameter int DW = dpsmc_pkg::DW,
    parameter int ROUTE_CH = dpsmc_pkg::ROUTE_CH
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic [dpsmc_pkg::APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dpsmc_pkg::APB_DW-1:0] pwdata,
    output logic [dpsmc_pkg::APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Routing fabric.
    input wire logic [ROUTE_CH-1:0] route_chan,
    output logic shift_out,
    // Neighbouring slices.
    input wire dpsmc_pkg::dpsmc_chain_in_t chain_in,
    output dpsmc_pkg::dpsmc_chain_out_t chain_out
);

    localparam logic [DW-1:0] ALL_ONES = 8'hFF;
    localparam logic [DW-1:0] ZERO = 8'h00;

    function automatic dpsmc_pkg::dpsmc_state_t reset_state();
        dpsmc_pkg::dpsmc_state_t s;
        s = '0;
        s.alu_result_mask = dpsmc_pkg::RST_MASK;
        s.top_cfg.top_idx = dpsmc_pkg::RST_TOP_IDX;
        return s;
    endfunction

    localparam dpsmc_pkg::dpsmc_state_t RST_STATE = reset_state();

    dpsmc_pkg::dpsmc_state_t s_q;
    dpsmc_pkg::dpsmc_state_t s_d;

    // Routed inputs.
    logic [dpsmc_pkg::NUM_IN-1:0] din;

    for (genvar g = 0; g < dpsmc_pkg::NUM_IN; g++) begin : g_insel
        assign din[g] = (int'(s_q.in_sel[g]) < ROUTE_CH) ? route_chan[s_q.in_sel[g]] : 1'b0;
    end

    logic [2:0] cfg_addr;
    dpsmc_pkg::dpsmc_dyn_word_t dw;
    assign cfg_addr = {din[dpsmc_pkg::IN_ADDR2], din[dpsmc_pkg::IN_ADDR1],
                       din[dpsmc_pkg::IN_ADDR0]};
    assign dw = dpsmc_pkg::dpsmc_dyn_word_t'(s_q.dyn[cfg_addr]);

    // Top bit position; with isolation off the full byte is used.
    logic [2:0] top_idx;
    logic [DW-1:0] low_mask;
    assign top_idx = s_q.top_cfg.top_enable ? s_q.top_cfg.top_idx : dpsmc_pkg::RST_TOP_IDX;
    assign low_mask = ALL_ONES >> (3'h7 - top_idx);

    // Operand sources.
    logic [DW-1:0] srca;
    logic [DW-1:0] srcb;
    assign srca = dw.srca_acc1 ? s_q.accumulator_one : s_q.accumulator_zero;

    always_comb begin
        unique case (dw.srcb)
            dpsmc_pkg::OB_OPER0: srcb = s_q.operand_reg_zero;
            dpsmc_pkg::OB_OPER1: srcb = s_q.operand_reg_one;
            dpsmc_pkg::OB_ACC0: srcb = s_q.accumulator_zero;
            dpsmc_pkg::OB_ACC1: srcb = s_q.accumulator_one;
        endcase
    end

    // A or B source per cycle
    dpsmc_pkg::dpsmc_src_t si_mode;
    assign si_mode = dw.shift_sel_b ? s_q.shift_cfg.shift_in_source_b
                                    : s_q.shift_cfg.shift_in_source_a;

    // Bit entering bit 0 on a left shift; it is also the CRC data input.
    logic si_left;
    always_comb begin
        unique case (si_mode)
            dpsmc_pkg::SRC_DEFAULT: si_left = s_q.shift_cfg.default_shift_bit;
            dpsmc_pkg::SRC_REGISTERED: si_left = s_q.sol;
            dpsmc_pkg::SRC_ROUTED: si_left = din[dpsmc_pkg::IN_SHIFT];
            dpsmc_pkg::SRC_CHAINED: si_left = chain_in.shift_from_right;
        endcase
    end

    logic top_bit;
    logic feedback_raw;
    logic feedback;
    assign top_bit = s_q.top_cfg.chain_top_bit ? chain_in.top_bit : srca[top_idx];
    assign feedback_raw = s_q.top_cfg.chain_feedback ? chain_in.crc_feedback
                                                     : (si_left ^ top_bit);
    assign feedback = dw.crc_feedback_enable ? feedback_raw : 1'b1;

    logic [DW-1:0] srcb_g;
    assign srcb_g = srcb & {DW{feedback}};

    // Carry in and the second adder operand.
    logic arith;
    logic borrow;
    logic cin;
    logic [DW-1:0] opb;
    dpsmc_pkg::dpsmc_src_t ci_mode;
    assign arith = dw.func inside {dpsmc_pkg::FN_INC, dpsmc_pkg::FN_DEC, dpsmc_pkg::FN_ADD,
                                   dpsmc_pkg::FN_SUB};
    assign borrow = dw.func inside {dpsmc_pkg::FN_DEC, dpsmc_pkg::FN_SUB};
    assign ci_mode = dw.carry_sel_b ? s_q.carry_cfg.carry_source_b
                                    : s_q.carry_cfg.carry_source_a;

    always_comb begin
        unique case (dw.func)
            dpsmc_pkg::FN_INC: opb = ZERO;
            dpsmc_pkg::FN_DEC: opb = ALL_ONES;
            dpsmc_pkg::FN_SUB: opb = ~srcb_g;
            default: opb = srcb_g;
        endcase
    end

    always_comb begin
        unique case (ci_mode)
            dpsmc_pkg::SRC_DEFAULT: cin = (dw.func == dpsmc_pkg::FN_INC) ||
                                          (dw.func == dpsmc_pkg::FN_SUB);
            dpsmc_pkg::SRC_REGISTERED: cin = s_q.carry;
            dpsmc_pkg::SRC_ROUTED: cin = din[dpsmc_pkg::IN_CARRY] ^ borrow;
            dpsmc_pkg::SRC_CHAINED: cin = chain_in.carry;
        endcase
    end

    // Full sum for the result; a sum of the isolated bits for carry out.
    logic [DW:0] sum;
    logic [DW:0] low_sum;
    logic carry_raw;
    assign sum = {1'b0, srca} + {1'b0, opb} + {{DW{1'b0}}, cin};
    assign low_sum = {1'b0, srca & low_mask} + {1'b0, opb & low_mask} + {{DW{1'b0}}, cin};
    assign carry_raw = low_sum[{1'b0, top_idx} + 4'h1];

    logic [DW-1:0] alu;
    always_comb begin
        unique case (dw.func)
            dpsmc_pkg::FN_PASS: alu = srca;
            dpsmc_pkg::FN_INC: alu = sum[DW-1:0];
            dpsmc_pkg::FN_DEC: alu = sum[DW-1:0];
            dpsmc_pkg::FN_ADD: alu = sum[DW-1:0];
            dpsmc_pkg::FN_SUB: alu = sum[DW-1:0];
            dpsmc_pkg::FN_XOR: alu = srca ^ srcb_g;
            dpsmc_pkg::FN_AND: alu = srca & srcb_g;
            dpsmc_pkg::FN_OR: alu = srca | srcb_g;
        endcase
    end

    logic [DW-1:0] res;
    assign res = alu & s_q.alu_result_mask;

    // Bit entering the top position on a right shift.
    logic si_right;
    always_comb begin
        unique case (si_mode)
            dpsmc_pkg::SRC_DEFAULT: si_right = s_q.shift_cfg.msb_shift_in ? res[top_idx]
                                                                         : s_q.shift_cfg.default_shift_bit;
            dpsmc_pkg::SRC_REGISTERED: si_right = s_q.sor;
            dpsmc_pkg::SRC_ROUTED: si_right = din[dpsmc_pkg::IN_SHIFT];
            dpsmc_pkg::SRC_CHAINED: si_right = chain_in.shift_from_left;
        endcase
    end

    logic [DW-1:0] sh_val;
    logic sol;
    logic sor;
    dpsmc_shifter #(
        .DW(DW)
    ) u_shifter (
        .value(res),
        .mode(dw.shift),
        .top_idx(top_idx),
        .si_left(si_left),
        .si_right(si_right),
        .result(sh_val),
        .shift_out_left(sol),
        .shift_out_right(sor)
    );

    // Register decode; misaligned addresses count as unmapped.
    logic dyn_hit;
    logic hit;
    assign dyn_hit = (paddr[11:5] == dpsmc_pkg::OFS_DYN_BASE[11:5]) && (paddr[1:0] == 2'b00);
    assign hit = dyn_hit || (paddr inside {dpsmc_pkg::OFS_SHIFT_CFG, dpsmc_pkg::OFS_TOP_BIT,
        dpsmc_pkg::OFS_MASK, dpsmc_pkg::OFS_CARRY_CFG, dpsmc_pkg::OFS_INPUT_SEL,
        dpsmc_pkg::OFS_ACCUM, dpsmc_pkg::OFS_OPERAND, dpsmc_pkg::OFS_QUEUE,
        dpsmc_pkg::OFS_STATUS});

    logic [dpsmc_pkg::APB_DW-1:0] rd;
    always_comb begin
        rd = '0;
        if (dyn_hit) begin
            rd[dpsmc_pkg::CFG_WORD_W-1:0] = s_q.dyn[paddr[4:2]];
        end else begin
            unique case (paddr)
                dpsmc_pkg::OFS_SHIFT_CFG: rd[6:0] = s_q.shift_cfg;
                dpsmc_pkg::OFS_TOP_BIT: rd[5:0] = s_q.top_cfg;
                dpsmc_pkg::OFS_MASK: rd[7:0] = s_q.alu_result_mask;
                dpsmc_pkg::OFS_CARRY_CFG: rd[7:0] = s_q.carry_cfg;
                dpsmc_pkg::OFS_INPUT_SEL: rd[26:0] = s_q.in_sel;
                dpsmc_pkg::OFS_ACCUM: rd[15:0] = {s_q.accumulator_one, s_q.accumulator_zero};
                dpsmc_pkg::OFS_OPERAND: rd[15:0] = {s_q.operand_reg_one, s_q.operand_reg_zero};
                dpsmc_pkg::OFS_QUEUE: rd[15:0] = {s_q.queue1, s_q.queue0};
                dpsmc_pkg::OFS_STATUS: rd[13:0] = {top_bit, feedback_raw, s_q.carry, s_q.sor,
                                                   s_q.sol, s_q.shift_out, res};
                default: rd = '0;
            endcase
        end
    end

    function automatic logic [DW-1:0] queue_src(dpsmc_pkg::dpsmc_qsrc_t sel, logic [DW-1:0] held,
                                                 logic [DW-1:0] a0, logic [DW-1:0] a1,
                                                 logic [DW-1:0] r);
        unique case (sel)
            dpsmc_pkg::QS_NONE: return held;
            dpsmc_pkg::QS_ACC0: return a0;
            dpsmc_pkg::QS_ACC1: return a1;
            dpsmc_pkg::QS_ALU: return r;
        endcase
    endfunction

    always_comb begin
        s_d = s_q;

        s_d.sol = sol;
        s_d.sor = sor;
        if (arith) begin
            s_d.carry = carry_raw;
        end

        s_d.shift_out = s_q.shift_cfg.out_sel_left ? sol : sor;
        s_d.chain_out.shift_to_left = sol;
        s_d.chain_out.shift_to_right = sor;
        s_d.chain_out.carry = carry_raw ^ borrow;
        s_d.chain_out.crc_feedback = feedback_raw;
        s_d.chain_out.top_bit = top_bit;

        s_d.load_prev = {din[dpsmc_pkg::IN_OPER1], din[dpsmc_pkg::IN_OPER0],
                         din[dpsmc_pkg::IN_QUEUE1], din[dpsmc_pkg::IN_QUEUE0]};
        s_d.load_pend = s_d.load_prev & ~s_q.load_prev;

        if (s_q.load_pend[0]) begin
            s_d.queue0 = queue_src(s_q.carry_cfg.queue0_source_select, s_q.queue0,
                                   s_q.accumulator_zero, s_q.accumulator_one, res);
        end
        if (s_q.load_pend[1]) begin
            s_d.queue1 = queue_src(s_q.carry_cfg.queue1_source_select, s_q.queue1,
                                   s_q.accumulator_zero, s_q.accumulator_one, res);
        end
        if (s_q.load_pend[2]) begin
            s_d.operand_reg_zero = s_q.queue0;
        end
        if (s_q.load_pend[3]) begin
            s_d.operand_reg_one = s_q.queue1;
        end

        unique case (dw.acc0_wr)
            dpsmc_pkg::WR_NONE: s_d.accumulator_zero = s_q.accumulator_zero;
            dpsmc_pkg::WR_ALU: s_d.accumulator_zero = res;
            dpsmc_pkg::WR_SHIFT: s_d.accumulator_zero = sh_val;
            dpsmc_pkg::WR_QUEUE: s_d.accumulator_zero = s_q.queue0;
        endcase
        unique case (dw.acc1_wr)
            dpsmc_pkg::WR_NONE: s_d.accumulator_one = s_q.accumulator_one;
            dpsmc_pkg::WR_ALU: s_d.accumulator_one = res;
            dpsmc_pkg::WR_SHIFT: s_d.accumulator_one = sh_val;
            dpsmc_pkg::WR_QUEUE: s_d.accumulator_one = s_q.queue1;
        endcase

        // One wait state: read data is captured in the first access cycle, write data in the second.
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        if (psel && penable && !s_q.pready) begin
            s_d.pready = 1'b1;
            s_d.pslverr = !hit;
            s_d.prdata = (pwrite || !hit) ? '0 : rd;
        end

        // A software write wins over a datapath update in the same cycle.
        if (psel && penable && s_q.pready && pwrite && hit) begin
            if (dyn_hit) begin
                s_d.dyn[paddr[4:2]] = pwdata[dpsmc_pkg::CFG_WORD_W-1:0];
            end else begin
                unique case (paddr)
                    dpsmc_pkg::OFS_SHIFT_CFG: s_d.shift_cfg = pwdata[6:0];
                    dpsmc_pkg::OFS_TOP_BIT: s_d.top_cfg = pwdata[5:0];
                    dpsmc_pkg::OFS_MASK: s_d.alu_result_mask = pwdata[7:0];
                    dpsmc_pkg::OFS_CARRY_CFG: s_d.carry_cfg = pwdata[7:0];
                    dpsmc_pkg::OFS_INPUT_SEL: s_d.in_sel = pwdata[26:0];
                    dpsmc_pkg::OFS_ACCUM: begin
                        s_d.accumulator_zero = pwdata[7:0];
                        s_d.accumulator_one = pwdata[15:8];
                    end
                    dpsmc_pkg::OFS_OPERAND: begin
                        s_d.operand_reg_zero = pwdata[7:0];
                        s_d.operand_reg_one = pwdata[15:8];
                    end
                    default: s_d.prdata = s_d.prdata;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign shift_out = s_q.shift_out;
    assign chain_out = s_q.chain_out;

endmodule

`default_nettype wire

// >>> test/dpsmc_nbr.sv
`default_nettype none

module dpsmc_nbr (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Bits from the neighbouring slices.
    output var dpsmc_pkg::dpsmc_chain_in_t chain_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt_q = 5'h00;
    always @(posedge pclk) cnt_q <= presetn ? cnt_q + 5'h0B : 5'h00;
    assign chain_in = cnt_q;
endmodule

`default_nettype wire

// >>> test/dpsmc_sva.sv
`default_nettype none

module dpsmc_sva (
    // Clock, reset and bus.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Datapath outputs.
    input wire logic shift_out,
    input wire dpsmc_pkg::dpsmc_chain_out_t chain_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_rdy_acc;
        pready |-> psel && penable;
    endproperty
    a_rdy_acc: assert property (p_rdy_acc) else $error("ready outside access");
    property p_wait;
        $rose(penable) |-> !pready ##1 pready;
    endproperty
    a_wait: assert property (p_wait) else $error("not one wait state");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_idle;
        !psel |=> !pready;
    endproperty
    a_idle: assert property (p_idle) else $error("ready while idle");
    property p_err;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("bad error reply");
    property p_wr_zero;
        pready && pwrite |-> prdata == 32'h0;
    endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("write returned data");
    property p_rst;
        $rose(presetn) |-> !pready && !shift_out && chain_out == 5'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared");
    property p_so_sel;
        shift_out == chain_out.shift_to_left || shift_out == chain_out.shift_to_right;
    endproperty
    a_so_sel: assert property (p_so_sel) else $error("shift out not a side");
    cover property (pready && pwrite);
    cover property (pready && pslverr);
    cover property ($rose(shift_out));
endmodule

bind dpsmc_top dpsmc_sva CHK (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shift_out(shift_out), .chain_out(chain_out));

`default_nettype wire

// >>> test/test_datapath_shift_mask_crc.sv
`default_nettype none

module test_datapath_shift_mask_crc;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, shift_out, err;
    logic [5:0] route_chan = 6'h00;
    dpsmc_pkg::dpsmc_chain_in_t chain_in;
    dpsmc_pkg::dpsmc_chain_out_t chain_out;
    int failures = 0, n_tests = 0;
    always #20 pclk = ~pclk;
    dpsmc_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .route_chan(route_chan),
        .shift_out(shift_out), .chain_in(chain_in), .chain_out(chain_out));
    dpsmc_nbr NBR (.pclk(pclk), .presetn(presetn), .chain_in(chain_in));
    task automatic complete_run;
        if (failures == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Called just after a rising edge; holds the request until ready is seen.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk({31'h0, pready === 1'b1}, 32'h1);
        if (pready !== 1'b1) complete_run();
        @(posedge pclk);
    endtask
    function automatic logic [7:0] sh(input logic [7:0] v, input logic [1:0] md, input logic si);
        case (md)
            2'h1: return {v[6:0], si};
            2'h2: return {si, v[7:1]};
            2'h3: return {v[3:0], v[7:4]};
            default: return v;
        endcase
    endfunction
    initial begin
        logic [7:0] a, m, v;
        logic si;
        logic [1:0] md;
        logic [2:0] cfg;
        void'($urandom(12135));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'hFF);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h07);
        apb(1'b0, 12'h0FC, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        // Config address stays on word 0; shift-in from channel 3, loads on 1 and 2.
        apb(1'b1, 12'h010, 32'h0061_0200);
        for (int i = 0; i < 24; i++) begin
            a = 8'($urandom);
            m = (i < 4) ? 8'hFF : 8'($urandom);
            md = 2'(i);
            cfg = (i == 4) ? 3'h0 : 3'($urandom);
            route_chan <= 6'h08 & 6'($urandom);
            apb(1'b1, 12'h008, {24'h0, m});
            apb(1'b1, 12'h014, {24'h0, a});
            apb(1'b1, 12'h000, {26'h0, cfg[2], 2'h0, cfg[1], 1'h0, cfg[0]});
            apb(1'b1, 12'h040, 32'h4000 | {24'h0, md, 6'h00});
            v = a & m;
            si = cfg[1] ? route_chan[3] : cfg[2];
            apb(1'b0, 12'h020, 32'h0);
            chk(rd[7:0], v);
            chk(rd[13:12], {a[7], a[7] ^ si});
            apb(1'b0, 12'h014, 32'h0);
            chk(rd[15:8], sh(v, md, si));
            @(negedge pclk);
            if (md != 2'h3 && md != (cfg[0] ? 2'h2 : 2'h1))
                chk(shift_out, cfg[0] ? v[7] : v[0]);
            if (md == 2'h0)
                chk({chain_out.shift_to_left, chain_out.shift_to_right}, {v[7], v[0]});
            @(posedge pclk);
        end
        apb(1'b1, 12'h00C, 32'h10);
        route_chan <= 6'h02;
        repeat (3) @(posedge pclk);
        apb(1'b0, 12'h01C, 32'h0);
        chk(rd[7:0], a);
        route_chan <= 6'h06;
        repeat (3) @(posedge pclk);
        apb(1'b0, 12'h018, 32'h0);
        chk(rd[7:0], a);
        apb(1'b1, 12'h014, {24'h0, ~a});
        repeat (3) @(posedge pclk);
        apb(1'b0, 12'h01C, 32'h0);
        chk(rd[7:0], a);
        complete_run();
    end
endmodule

`default_nettype wire
